// >>> logic/i2c_flag_pkg.sv
// Package for the I2C status flag block: types, states and constants.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package i2c_flag_pkg;
    // Stages on the pin sampling chain.
    localparam int SYNC_STAGES = 3;
    // Bit count per byte including the acknowledge clock.
    localparam int BYTE_CLOCKS = 9;
    localparam logic [3:0] ACK_CLOCK = 4'h9;
    localparam logic [3:0] DIR_CLOCK = 4'h8;
    localparam logic [3:0] FIRST_CLOCK = 4'h1;
    // Reset values of the flags.
    localparam logic FLAG_RESET = 1'b0;

    // Bus events seen by the sampler.
    typedef struct packed {
        logic start_det;
        logic stop_det;
        logic scl_rise;
        logic scl_fall;
        logic sda_level;
    } bus_event_t;

    // Software commands and controls.
    typedef struct packed {
        logic comm_release_cmd;
        logic wait_release_cmd;
        logic operation_enable_bit;
        logic arbitration_lost_flag;
        logic master_mode;
        logic start_generated;
        logic in_comm;
    } ctrl_t;

    // Status flags as seen by software.
    typedef struct packed {
        logic transmit_direction_flag;
        logic ack_detected_flag;
        logic start_detected_flag;
        logic stop_detected_flag;
    } status_t;

    // Byte phase tracker.
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_ADDR = 3'b010,
        PH_DATA = 3'b100
    } phase_t;
endpackage
`default_nettype wire

// >>> logic/i2c_pin_sampler.sv
// Samples the serial clock and data pins and derives bus events.
// Assumes pins are asynchronous to sys_clk.
`default_nettype none
module i2c_pin_sampler (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic scl_in, // Serial clock pin level.
    input wire logic sda_in, // Serial data pin level.
    output i2c_flag_pkg::bus_event_t ev // Decoded bus events.
);
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;

    ////////////////////////////////////////////////////////////////////////
    // Three stages; a level is accepted once stages two and three agree,
    // so the first stage never feeds any decision.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_reg <= sda_sync_reg[2];
            end
        end
    end

    // A start is data falling with clock high; a stop is data rising.
    always_comb begin
        ev.scl_rise = 1'b0;
        ev.scl_fall = 1'b0;
        ev.start_det = 1'b0;
        ev.stop_det = 1'b0;
        ev.sda_level = sda_reg;
        if ((scl_sync_reg[1] == scl_sync_reg[2]) &&
            (scl_sync_reg[2] != scl_reg)) begin
            ev.scl_rise = scl_sync_reg[2];
            ev.scl_fall = !scl_sync_reg[2];
        end
        if (scl_reg && (sda_sync_reg[1] == sda_sync_reg[2]) &&
            (sda_sync_reg[2] != sda_reg)) begin
            ev.start_det = !sda_sync_reg[2];
            ev.stop_det = sda_sync_reg[2];
        end
    end
endmodule
`default_nettype wire

// >>> logic/i2c_status_flag_logic.sv
// Status flag logic of an I2C bus interface: direction, ack, start, stop.
// Assumes commands are one-cycle pulses on sys_clk and pins are async.
//
// Functional notes
// - Direction flag low keeps data pin released.
// - Direction flag high drives shift-out latch value once the first byte ends.
// - Stop, release, disable, wait-release, arbitration clear direction.
// - Master start sets; direction bit decides flag.
// - Slave read bit sets; start or idle clears.
// - Wait-release at ninth clock clears, releases.
// - Data low at ninth rising edge sets ack.
// - Ack cleared by stop, next byte, release, disable.
// - Start condition sets start flag, address period.
// - Start flag cleared at next byte or stop.
// - Stop condition sets the stop flag.
// - Stop flag cleared at first address clock or by disable.
// - Disable stops and resets; release abandons transfer.
`default_nettype none
module i2c_status_flag_logic (
    input wire logic sys_clk, // 50 MHz system clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic serial_clock_pin_in, // Clock pin level.
    input wire logic serial_data_pin_in, // Data pin level.
    output logic serial_data_pin_out, // Data pin output value.
    output logic serial_data_pin_oe_n, // Low while data pin is driven.
    input wire logic shift_out_latch, // Bit to send on the data line.
    input wire logic comm_release_cmd, // Pulse: abandon transfer.
    input wire logic wait_release_cmd, // Pulse: release ninth-clock wait.
    input wire logic operation_enable_bit, // Level: interface enabled.
    input wire logic arbitration_lost_flag, // Level: arbitration lost.
    input wire logic master_mode, // Level: acting as master.
    input wire logic start_generated, // Pulse: master issued a start.
    input wire logic in_comm, // Level: taking part in communication.
    output logic transmit_direction_flag, // Transmit status.
    output logic ack_detected_flag, // Acknowledge seen.
    output logic start_detected_flag, // Start seen, address period.
    output logic stop_detected_flag, // Stop seen, bus free.
    output logic wait_held // Ninth-clock wait in effect.
);
    i2c_flag_pkg::bus_event_t ev;
    i2c_flag_pkg::phase_t phase_reg;
    logic [3:0] bit_cnt_reg;
    logic first_byte_reg;
    logic enable_d_reg;
    logic ald_d_reg;
    logic disable_evt;
    logic ald_rise;
    logic first_clk_rise;
    logic ack_rise;
    logic dir_rise;
    logic first_byte_end;
    logic stop_pend_reg;
    i2c_flag_pkg::status_t st_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and event decode.
    i2c_pin_sampler u_sampler (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .scl_in(serial_clock_pin_in),
        .sda_in(serial_data_pin_in),
        .ev(ev)
    );

    ////////////////////////////////////////////////////////////////////////
    // Edge history of enable and arbitration loss.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enable_d_reg <= 1'b0;
            ald_d_reg <= 1'b0;
        end else begin
            enable_d_reg <= operation_enable_bit;
            ald_d_reg <= arbitration_lost_flag;
        end
    end

    // Disable is taken as a level too, so flags stay clear while off.
    assign disable_evt = (enable_d_reg && !operation_enable_bit) ||
                         !operation_enable_bit;
    assign ald_rise = arbitration_lost_flag && !ald_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Clock counter within a byte; a start resets it, a release idles it.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || disable_evt || comm_release_cmd) begin
            bit_cnt_reg <= 4'h0;
            first_byte_reg <= 1'b0;
            phase_reg <= i2c_flag_pkg::PH_IDLE;
        end else if (ev.start_det) begin
            bit_cnt_reg <= 4'h0;
            first_byte_reg <= 1'b1;
            phase_reg <= i2c_flag_pkg::PH_ADDR;
        end else if (ev.stop_det) begin
            bit_cnt_reg <= 4'h0;
            first_byte_reg <= 1'b0;
            phase_reg <= i2c_flag_pkg::PH_IDLE;
        end else if (ev.scl_rise) begin
            if (bit_cnt_reg == i2c_flag_pkg::ACK_CLOCK) begin
                bit_cnt_reg <= i2c_flag_pkg::FIRST_CLOCK;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end else if (ev.scl_fall && first_byte_end) begin
            first_byte_reg <= 1'b0;
            phase_reg <= i2c_flag_pkg::PH_DATA;
        end
    end

    // Named clock moments on the decoded bus.
    assign first_clk_rise = ev.scl_rise &&
        ((bit_cnt_reg == 4'h0) ||
         (bit_cnt_reg == i2c_flag_pkg::ACK_CLOCK));
    assign ack_rise = ev.scl_rise &&
        (bit_cnt_reg == i2c_flag_pkg::DIR_CLOCK);
    assign dir_rise = ev.scl_rise && first_byte_reg &&
        (bit_cnt_reg == (i2c_flag_pkg::DIR_CLOCK - 4'h1));
    assign first_byte_end = first_byte_reg &&
        (bit_cnt_reg == i2c_flag_pkg::ACK_CLOCK);

    ////////////////////////////////////////////////////////////////////////
    // Ninth-clock wait: held from the ninth falling edge until released.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || disable_evt || comm_release_cmd || ev.stop_det) begin
            wait_held <= 1'b0;
        end else if (wait_release_cmd) begin
            wait_held <= 1'b0;
        end else if (ev.scl_fall &&
                     (bit_cnt_reg == i2c_flag_pkg::ACK_CLOCK)) begin
            wait_held <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction flag; every clear term is tested before any set term.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg.transmit_direction_flag <= i2c_flag_pkg::FLAG_RESET;
        end else if (ev.stop_det || comm_release_cmd || disable_evt ||
                     ald_rise) begin
            st_reg.transmit_direction_flag <= 1'b0;
        end else if (wait_release_cmd && wait_held &&
                     st_reg.transmit_direction_flag) begin
            st_reg.transmit_direction_flag <= 1'b0;
        end else if (wait_release_cmd) begin
            st_reg.transmit_direction_flag <= 1'b0;
        end else if (master_mode) begin
            if (dir_rise && shift_out_latch) begin
                st_reg.transmit_direction_flag <= 1'b0;
            end else if (start_generated) begin
                st_reg.transmit_direction_flag <= 1'b1;
            end
        end else begin
            if (ev.start_det || !in_comm) begin
                st_reg.transmit_direction_flag <= 1'b0;
            end else if (dir_rise && ev.sda_level) begin
                st_reg.transmit_direction_flag <= 1'b1;
            end
        end
    end

    // Acknowledge flag.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg.ack_detected_flag <= i2c_flag_pkg::FLAG_RESET;
        end else if (ev.stop_det || comm_release_cmd || disable_evt ||
                     first_clk_rise) begin
            st_reg.ack_detected_flag <= 1'b0;
        end else if (ack_rise && !ev.sda_level) begin
            st_reg.ack_detected_flag <= 1'b1;
        end
    end

    // Start flag spans the address byte up to the next byte's first clock.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg.start_detected_flag <= i2c_flag_pkg::FLAG_RESET;
        end else if (ev.stop_det || comm_release_cmd || disable_evt ||
                     (first_clk_rise &&
                      phase_reg == i2c_flag_pkg::PH_DATA)) begin
            st_reg.start_detected_flag <= 1'b0;
        end else if (ev.start_det) begin
            st_reg.start_detected_flag <= 1'b1;
        end
    end

    // A start arms the stop-flag clear; release does not touch it.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || disable_evt) begin
            stop_pend_reg <= 1'b0;
        end else if (ev.start_det && st_reg.stop_detected_flag) begin
            stop_pend_reg <= 1'b1;
        end else if (first_clk_rise) begin
            stop_pend_reg <= 1'b0;
        end
    end

    // Stop flag.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg.stop_detected_flag <= i2c_flag_pkg::FLAG_RESET;
        end else if (disable_evt ||
                     (stop_pend_reg && first_clk_rise &&
                      phase_reg == i2c_flag_pkg::PH_ADDR)) begin
            st_reg.stop_detected_flag <= 1'b0;
        end else if (ev.stop_det) begin
            st_reg.stop_detected_flag <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pin drive. Driving waits for the end of the first byte so the
    // address phase and its acknowledge are never disturbed.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            serial_data_pin_out <= 1'b1;
            serial_data_pin_oe_n <= 1'b1;
        end else if (!st_reg.transmit_direction_flag ||
                     phase_reg != i2c_flag_pkg::PH_DATA) begin
            serial_data_pin_out <= 1'b1;
            serial_data_pin_oe_n <= 1'b1;
        end else begin
            serial_data_pin_out <= shift_out_latch;
            serial_data_pin_oe_n <= 1'b0;
        end
    end

    // Flag outputs straight from their flops.
    assign transmit_direction_flag = st_reg.transmit_direction_flag;
    assign ack_detected_flag = st_reg.ack_detected_flag;
    assign start_detected_flag = st_reg.start_detected_flag;
    assign stop_detected_flag = st_reg.stop_detected_flag;
endmodule
`default_nettype wire

// >>> tb/i2c_status_flag_monitor.sv
// Checker for the I2C status flag block, bound to its top module.
// Assumes commands are one-cycle pulses and pins are sampled inside.
`default_nettype none
module i2c_status_flag_monitor (
    input wire logic sys_clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic serial_clock_pin_in, // Clock pin.
    input wire logic serial_data_pin_in, // Data pin.
    input wire logic serial_data_pin_oe_n, // Data drive enable.
    input wire logic comm_release_cmd, // Release pulse.
    input wire logic wait_release_cmd, // Wait release pulse.
    input wire logic operation_enable_bit, // Enable.
    input wire logic arbitration_lost_flag, // Arbitration lost.
    input wire logic transmit_direction_flag, // Direction.
    input wire logic ack_detected_flag, // Ack.
    input wire logic start_detected_flag, // Start.
    input wire logic stop_detected_flag // Stop.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] scl_hist_reg;
    logic [7:0] sda_hist_reg;
    ////////////////////////////////////////
    // Pin history ties a flag edge to a recent pin edge despite sync delay.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_hist_reg <= 8'hff;
            sda_hist_reg <= 8'hff;
        end else begin
            scl_hist_reg <= {scl_hist_reg[6:0], serial_clock_pin_in};
            sda_hist_reg <= {sda_hist_reg[6:0], serial_data_pin_in};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_rx_released: assert property (!transmit_direction_flag [*2]
        |-> serial_data_pin_oe_n) else $error("data driven in receive");
    a_tx_drives: assert property (!serial_data_pin_oe_n
        |-> transmit_direction_flag || $past(transmit_direction_flag))
        else $error("data driven without transmit");
    a_disable_clears: assert property (!operation_enable_bit
        |=> {transmit_direction_flag, ack_detected_flag, start_detected_flag,
        stop_detected_flag} == 4'h0) else $error("flags kept when off");
    a_release_clears: assert property (comm_release_cmd |=>
        !(transmit_direction_flag || ack_detected_flag || start_detected_flag))
        else $error("flags kept after release");
    a_wait_release: assert property (wait_release_cmd |=>
        !transmit_direction_flag ##[0:1] serial_data_pin_oe_n)
        else $error("wait release left data driven");
    a_arb_clears: assert property ($rose(arbitration_lost_flag)
        |=> !transmit_direction_flag) else $error("direction kept on loss");
    a_stop_holds: assert property ($fell(stop_detected_flag)
        |-> !$past(operation_enable_bit) || scl_hist_reg != 8'hff)
        else $error("stop flag cleared without clock rise");
    a_ack_needs_low: assert property ($rose(ack_detected_flag)
        |-> sda_hist_reg != 8'hff) else $error("ack set with data high");
    a_stop_clears: assert property ($rose(stop_detected_flag)
        |-> !start_detected_flag && !ack_detected_flag)
        else $error("stop left start or ack set");
    a_reset_state: assert property ($rose(rst_n) |->
        serial_data_pin_oe_n &&
        !(transmit_direction_flag || ack_detected_flag ||
        start_detected_flag || stop_detected_flag)) else $error("bad reset");
endmodule
bind i2c_status_flag_logic i2c_status_flag_monitor i2c_status_flag_monitor_i (
    .sys_clk, .rst_n, .serial_clock_pin_in, .serial_data_pin_in,
    .serial_data_pin_oe_n, .comm_release_cmd, .wait_release_cmd,
    .operation_enable_bit, .arbitration_lost_flag, .transmit_direction_flag,
    .ack_detected_flag, .start_detected_flag, .stop_detected_flag);
`default_nettype wire

// >>> tb/i2c_bus_model.sv
// Model of another master on the bus: drives clock and data lines.
// Assumes a pull-up on both lines, so a released line reads high.
`default_nettype none
module i2c_bus_model (
    output logic scl, // Clock line, high when released.
    output logic sda_drv // Data drive, high when released.
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////
    // The clock stands high between frames; one bit takes 160 ns.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Raises both lines first so it also serves as a repeated start.
    task automatic start();
        sda_drv = 1'b1;
        #40 scl = 1'b1;
        #80 sda_drv = 1'b0;
        #80 scl = 1'b0;
        #80;
    endtask
    task automatic clk_bit(input logic b);
        sda_drv = b;
        #40 scl = 1'b1;
        #80 scl = 1'b0;
        #40;
    endtask
    task automatic send_byte(input logic [7:0] v, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(v[i]);
        end
        clk_bit(!ack);
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #40 scl = 1'b1;
        #80 sda_drv = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// >>> tb/i2c_status_flag_logic_tb_top.sv
// Testbench for the I2C status flag block with a bus model partner.
// Assumes the checker is bound to the design from its own file.
`default_nettype none
module i2c_status_flag_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic latch = 1'b0;
    logic scl, sda_drv, sda_out, sda_oe_n, wait_held;
    wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
    wire logic [3:0] pins = {1'b0, sda_oe_n, sda_out, wait_held};
    i2c_flag_pkg::ctrl_t ctrl = '0;
    i2c_flag_pkg::status_t st;
    int n_errors = 0;
    int check_count = 0;
    ////////////////////////////////////////
    always #10 sys_clk = ~sys_clk;
    i2c_bus_model i2c_bus_model_i (.scl(scl), .sda_drv(sda_drv));
    i2c_status_flag_logic i2c_status_flag_logic_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .serial_clock_pin_in(scl),
        .serial_data_pin_in(sda_line), .serial_data_pin_out(sda_out),
        .serial_data_pin_oe_n(sda_oe_n), .shift_out_latch(latch),
        .comm_release_cmd(ctrl.comm_release_cmd),
        .wait_release_cmd(ctrl.wait_release_cmd),
        .operation_enable_bit(ctrl.operation_enable_bit),
        .arbitration_lost_flag(ctrl.arbitration_lost_flag),
        .master_mode(ctrl.master_mode), .start_generated(ctrl.start_generated),
        .in_comm(ctrl.in_comm), .wait_held(wait_held),
        .transmit_direction_flag(st.transmit_direction_flag),
        .ack_detected_flag(st.ack_detected_flag),
        .start_detected_flag(st.start_detected_flag),
        .stop_detected_flag(st.stop_detected_flag));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Waits out the pin synchroniser before anything is compared.
    task automatic settle();
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    // Bits are start generated, wait release and communication release.
    task automatic pulse(input logic [2:0] sel);
        @(posedge sys_clk);
        #1 {ctrl.start_generated, ctrl.wait_release_cmd,
            ctrl.comm_release_cmd} = sel;
        @(posedge sys_clk);
        #1 {ctrl.start_generated, ctrl.wait_release_cmd,
            ctrl.comm_release_cmd} = 3'h0;
        settle();
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // The full run takes some 16 us, so 200 us means a hang.
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
    initial begin
        ctrl.operation_enable_bit = 1'b1;
        ctrl.in_comm = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        check(st, 4'h0);
        check(pins, 4'h6);
        $display("test reset done");
        i2c_bus_model_i.start();
        settle();
        check(st, 4'h2);
        i2c_bus_model_i.send_byte(8'ha4, 1'b1);
        settle();
        check(st, 4'h6);
        check(pins[2], 1'b1);
        i2c_bus_model_i.clk_bit(1'b1);
        settle();
        check(st, 4'h0);
        i2c_bus_model_i.stop();
        settle();
        check(st, 4'h1);
        pulse(3'h1);
        check(st, 4'h1);
        i2c_bus_model_i.start();
        settle();
        check(st, 4'h3);
        i2c_bus_model_i.clk_bit(1'b1);
        settle();
        check(st, 4'h2);
        $display("test slave write done");
        i2c_bus_model_i.start();
        i2c_bus_model_i.send_byte(8'ha5, 1'b1);
        settle();
        check(st, 4'he);
        check(pins, 4'h1);
        latch = 1'b1;
        settle();
        check(pins, 4'h3);
        pulse(3'h2);
        check(st, 4'h6);
        check(pins, 4'h6);
        i2c_bus_model_i.start();
        i2c_bus_model_i.send_byte(8'ha5, 1'b1);
        i2c_bus_model_i.start();
        settle();
        check(st.transmit_direction_flag, 1'b0);
        i2c_bus_model_i.send_byte(8'ha5, 1'b1);
        ctrl.in_comm = 1'b0;
        settle();
        check(st.transmit_direction_flag, 1'b0);
        ctrl.in_comm = 1'b1;
        i2c_bus_model_i.stop();
        settle();
        check(st, 4'h1);
        $display("test slave read done");
        ctrl.master_mode = 1'b1;
        latch = 1'b0;
        pulse(3'h4);
        i2c_bus_model_i.start();
        settle();
        check(st.transmit_direction_flag, 1'b1);
        i2c_bus_model_i.send_byte(8'ha4, 1'b1);
        settle();
        check(st.transmit_direction_flag, 1'b1);
        ctrl.arbitration_lost_flag = 1'b1;
        settle();
        check(st.transmit_direction_flag, 1'b0);
        ctrl.arbitration_lost_flag = 1'b0;
        pulse(3'h4);
        latch = 1'b1;
        i2c_bus_model_i.start();
        i2c_bus_model_i.send_byte(8'ha5, 1'b1);
        settle();
        check(st.transmit_direction_flag, 1'b0);
        i2c_bus_model_i.stop();
        ctrl.master_mode = 1'b0;
        $display("test master done");
        i2c_bus_model_i.start();
        ctrl.operation_enable_bit = 1'b0;
        settle();
        check(st, 4'h0);
        i2c_bus_model_i.start();
        settle();
        check(st, 4'h0);
        $display("test disable done");
        summarize();
    end
endmodule
`default_nettype wire
